// ===== ssp_pkg.sv
// package for the synchronous serial port: register offsets, fields, reset values
// assumes a byte-wide register window reached over classic wishbone, one register per word
package ssp_pkg;
	// offsets are register indices; byte address is four times the index
	localparam logic [11:0] IDX_CTRL_ONE  = 12'h780;
	localparam logic [11:0] IDX_CTRL_TWO  = 12'h781;
	localparam logic [11:0] IDX_BAUD      = 12'h782;
	localparam logic [11:0] IDX_STATUS    = 12'h783;
	localparam logic [11:0] IDX_DATA_HIGH = 12'h784;
	localparam logic [11:0] IDX_DATA_LOW  = 12'h785;
	localparam logic [11:0] IDX_RSVD_A    = 12'h786;
	localparam logic [11:0] IDX_RSVD_B    = 12'h787;
	localparam logic [11:0] IDX_IRQ_MASK  = 12'h788;
	localparam int          ADDR_LSB      = 2;
	// control one fields
	localparam int CR1_IRQ_EN    = 7;
	localparam int CR1_ENABLE    = 6;
	localparam int CR1_TXE_IRQ   = 5;
	localparam int CR1_MASTER    = 4;
	localparam int CR1_POLARITY  = 3;
	localparam int CR1_PHASE     = 2;
	localparam int CR1_SEL_OUT   = 1;
	localparam int CR1_LSB_FIRST = 0;
	// control two fields
	localparam int CR2_WIDTH     = 6;
	localparam logic [7:0] CR2_MASK  = 8'h40;
	// baud rate fields
	localparam logic [7:0] BAUD_MASK = 8'h77;
	localparam int BAUD_PRE_LSB  = 4;
	// status fields
	localparam int SR_DONE       = 7;
	localparam int SR_EMPTY      = 5;
	// reset values
	localparam logic [7:0] CR1_RESET  = 8'h04;
	localparam logic [7:0] CR2_RESET  = 8'h00;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	localparam logic [1:0] MASK_RESET = 2'h0;
	// word widths
	localparam logic [5:0] EDGES_8  = 6'h10;
	localparam logic [5:0] EDGES_16 = 6'h20;
endpackage : ssp_pkg

// ===== ssp_serial_port.sv
// synchronous serial port, phase-zero and phase-one formats, master and slave,
// 8 or 16 bit words, with wishbone register access and a level interrupt.
// assumes pins arrive unsynchronised and are resolved by the bench from the enables.
//
// Functional notes
// - the polarity bit only chooses the idle level of the serial clock.
// - the phase bit chooses which clock edges sample and which shift.
// - both ends must share phase and polarity, which software may change between words.
// - with phase zero the first clock edge samples the first bit at both ends.
// - with phase zero a master gives the first clock edge half a period after select falls.
// - with phase zero, on the second edge the sampled bit enters the shift register at the chosen end.
// - with phase zero, after each even edge but the last the master drives its next bit onto the master-out line.
// - an 8-bit word takes 16 clock edges; phase zero samples on odd and shifts on even edges, phase one the other way.
// - a word takes twice its configured width in clock edges.
// - the received word is copied to the data register only once the last bit is in.
// - after the last edge the two ends have exchanged their data words; here only as a phase-zero master.
// - a phase-zero slave sends each bit one shift late; phase one never loads the data register.
// - after the last edge the transfer-done flag is set.
// - the master drives clock and master-out, the slave drives master-in.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ns
module ssp_serial_port (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	output logic             irq,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe,
	input  wire logic        ss_n_i,
	output logic             ss_n_o,
	output logic             ss_n_oe
);
	typedef enum logic [1:0] {SSP_IDLE, SSP_LEAD, SSP_RUN, SSP_TAIL} ssp_state_t;

	// register state
	logic [7:0]  cr1_reg, cr2_reg, baud_reg;
	logic [1:0]  mask_reg;
	logic        done_reg, empty_reg, txe_ev_reg;
	logic [15:0] tx_reg, rx_reg, shift_reg;
	logic [5:0]  edge_reg;
	logic        in_bit_reg;
	ssp_state_t  state_reg;
	logic [11:0] div_reg;
	// synchronisers
	logic [1:0]  sck_s, mosi_s, miso_s, ss_s;
	logic        sck_d_reg;

	// configuration decode
	wire         enable   = cr1_reg[ssp_pkg::CR1_ENABLE];
	wire         master   = cr1_reg[ssp_pkg::CR1_MASTER];
	wire         polarity = cr1_reg[ssp_pkg::CR1_POLARITY];
	wire         phase    = cr1_reg[ssp_pkg::CR1_PHASE];
	wire         lsb_first_select  = cr1_reg[ssp_pkg::CR1_LSB_FIRST];
	wire         word_width_select = cr2_reg[ssp_pkg::CR2_WIDTH];
	wire [5:0]   last_edge = word_width_select ? ssp_pkg::EDGES_16 : ssp_pkg::EDGES_8;
	wire [3:0]   msb_pos   = word_width_select ? 4'hF : 4'h7;

	// half period of the serial clock in mclk cycles: (pre+1) * 2^(rate)
	wire [2:0]   pre_sel   = baud_reg[6:4];
	wire [2:0]   rate_sel  = baud_reg[2:0];
	wire [11:0]  half_cnt  = 12'((({9'h000, pre_sel} + 12'h001) << rate_sel) - 12'h001);
	wire         tick      = (div_reg == 12'h000);

	// wishbone decode
	wire [11:0]  reg_idx   = wb_adr_i[13:2];
	wire         wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire         hit       = (wb_adr_i[31:14] == 18'h00000) &&
	                         (reg_idx >= ssp_pkg::IDX_CTRL_ONE) &&
	                         (reg_idx <= ssp_pkg::IDX_IRQ_MASK);
	wire         wr_lane   = wb_req & hit & wb_we_i & wb_sel_i[0];
	wire [7:0]   wdat      = wb_dat_i[7:0];
	wire         wr_cr1    = wr_lane && reg_idx == ssp_pkg::IDX_CTRL_ONE;
	wire         wr_cr2    = wr_lane && reg_idx == ssp_pkg::IDX_CTRL_TWO;
	wire         wr_baud   = wr_lane && reg_idx == ssp_pkg::IDX_BAUD;
	wire         wr_status = wr_lane && reg_idx == ssp_pkg::IDX_STATUS;
	wire         wr_high   = wr_lane && reg_idx == ssp_pkg::IDX_DATA_HIGH;
	wire         wr_low    = wr_lane && reg_idx == ssp_pkg::IDX_DATA_LOW;
	wire         wr_mask   = wr_lane && reg_idx == ssp_pkg::IDX_IRQ_MASK;
	wire         rd_low    = wb_req & hit & ~wb_we_i && reg_idx == ssp_pkg::IDX_DATA_LOW;

	// bit selection helpers, used for the transmit bit on both master-out and master-in
	function automatic logic [3:0] ssp_pos(input logic lsb, input logic [3:0] top,
	                                      input logic [4:0] n);
		ssp_pos = lsb ? n[3:0] : 4'(top - n[3:0]);
	endfunction : ssp_pos

	// edge bookkeeping: with phase zero odd edges sample (counter even before the edge), even edges shift; phase one swaps them
	wire [4:0]   bit_num   = edge_reg[5:1];
	wire         odd_edge  = ~edge_reg[0];
	wire [3:0]   tx_pos    = ssp_pos(lsb_first_select, msb_pos, bit_num);
	wire [3:0]   tx_pos_nx = ssp_pos(lsb_first_select, msb_pos, 5'(bit_num + 5'h01));
	wire [15:0]  shifted   = lsb_first_select ? {in_bit_reg, shift_reg[15:1]}
	                                          : {shift_reg[14:0], in_bit_reg};
	wire [15:0]  rx_word   = (lsb_first_select && !word_width_select) ? {8'h00, shifted[15:8]}
	                                                                  : shifted;

	// slave side edge detection, read from the second synchroniser stage only
	wire         sel_low   = ~ss_s[1];
	wire         sck_rise  = sck_s[1] & ~sck_d_reg;
	wire         sck_fall  = ~sck_s[1] & sck_d_reg;
	wire         sck_lead  = polarity ? sck_fall : sck_rise;
	wire         sck_trail = polarity ? sck_rise : sck_fall;
	// with phase zero the leading edge samples; with phase one the trailing edge does
	wire         s_sample  = phase ? sck_trail : sck_lead;
	wire         s_shift   = phase ? sck_lead  : sck_trail;
	wire         slave_on  = enable & ~master & sel_low;
	wire         data_in   = master ? miso_s[1] : mosi_s[1];

	// master edge timing from the divider
	// the lead's own tick is edge one, half a period after select falls
	wire         m_edge    = ((state_reg == SSP_LEAD) | (state_reg == SSP_RUN)) & tick;
	wire         m_start   = enable & master & (state_reg == SSP_IDLE) & ~empty_reg;
	// in phase one, edge 1 is the shift edge, so count edges from the leading one
	wire         ev_sample = master ? (m_edge & (phase ? ~odd_edge : odd_edge))
	                                : (slave_on & s_sample);
	wire         ev_edge   = master ? m_edge : (slave_on & (s_sample | s_shift));
	wire         ev_last   = ev_edge && (edge_reg == 6'(last_edge - 6'h01));
	wire         ev_shift  = ev_edge & ~ev_sample;
	wire [3:0]   tx_first  = ssp_pos(lsb_first_select, msb_pos, 5'h00);

	// synchronisers for every pin input
	always_ff @(posedge mclk) begin
		sck_s     <= {sck_s[0], sck_i};
		mosi_s    <= {mosi_s[0], mosi_i};
		miso_s    <= {miso_s[0], miso_i};
		ss_s      <= {ss_s[0], ss_n_i};
		sck_d_reg <= sck_s[1];
	end

	// control one; polarity and phase may change between words only
	always_ff @(posedge mclk) begin
		if (rst) begin
			cr1_reg <= ssp_pkg::CR1_RESET;
		end else if (wr_cr1) begin
			cr1_reg <= wdat;
		end
	end

	// control two keeps only the width bit
	always_ff @(posedge mclk) begin
		if (rst) begin
			cr2_reg <= ssp_pkg::CR2_RESET;
		end else if (wr_cr2) begin
			cr2_reg <= wdat & ssp_pkg::CR2_MASK;
		end
	end

	// baud rate; unused bits read back as zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			baud_reg <= ssp_pkg::BAUD_RESET;
		end else if (wr_baud) begin
			baud_reg <= wdat & ssp_pkg::BAUD_MASK;
		end
	end

	// interrupt mask, packed from the status bit positions
	always_ff @(posedge mclk) begin
		if (rst) begin
			mask_reg <= ssp_pkg::MASK_RESET;
		end else if (wr_mask) begin
			mask_reg <= {wdat[ssp_pkg::SR_DONE], wdat[ssp_pkg::SR_EMPTY]};
		end
	end

	// transmit data bytes; high byte first, the low byte queues the word
	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_reg <= 16'h0000;
		end else begin
			if (wr_high) tx_reg[15:8] <= wdat;
			if (wr_low)  tx_reg[7:0]  <= wdat;
		end
	end

	// empty level: a fresh word wins over the start that takes the old one
	wire         slave_take = !master && slave_on && edge_reg == 6'h00 && ev_edge;
	always_ff @(posedge mclk) begin
		if (rst) begin
			empty_reg <= 1'b1;
		end else if (wr_low) begin
			empty_reg <= 1'b0;
		end else if (m_start || slave_take) begin
			empty_reg <= 1'b1;
		end
	end

	// done flag; a hardware set wins over a software clear in the same cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			done_reg <= 1'b0;
		end else if (ev_last) begin
			done_reg <= 1'b1;
		end else if (wr_status && wdat[ssp_pkg::SR_DONE]) begin
			done_reg <= 1'b0;
		end
	end

	// empty event for the interrupt, sticky until written with a one
	always_ff @(posedge mclk) begin
		if (rst) begin
			txe_ev_reg <= 1'b0;
		end else if (m_start) begin
			txe_ev_reg <= 1'b1;
		end else if (wr_status && wdat[ssp_pkg::SR_EMPTY]) begin
			txe_ev_reg <= 1'b0;
		end
	end

	// half-period divider, held at reload while idle so the lead is a whole half period
	always_ff @(posedge mclk) begin
		if (rst || !enable) begin
			div_reg <= 12'h000;
		end else if (state_reg == SSP_IDLE || tick) begin
			div_reg <= half_cnt;
		end else begin
			div_reg <= 12'(div_reg - 12'h001);
		end
	end

	// master sequencer: select, half-period lead, 2n edges, half-period tail
	always_ff @(posedge mclk) begin
		if (rst || !enable) begin
			state_reg <= SSP_IDLE;
		end else begin
			case (state_reg)
				SSP_IDLE: if (m_start) state_reg <= SSP_LEAD;
				SSP_LEAD: if (tick) state_reg <= SSP_RUN;
				SSP_RUN:  if (ev_last) state_reg <= SSP_TAIL;
				SSP_TAIL: if (tick) state_reg <= SSP_IDLE;
				default:  state_reg <= SSP_IDLE;
			endcase
		end
	end

	// edge counter shared by master and slave, cleared at each new word
	always_ff @(posedge mclk) begin
		if (rst || m_start || (!master && !slave_on)) begin
			edge_reg <= 6'h00;
		end else if (ev_edge) begin
			edge_reg <= ev_last ? 6'h00 : 6'(edge_reg + 6'h01);
		end
	end

	// sampled input bit, held until the following shift edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			in_bit_reg <= 1'b0;
		end else if (ev_sample) begin
			in_bit_reg <= data_in;
		end
	end

	// shift register; cleared at a start so short words read zero above them
	always_ff @(posedge mclk) begin
		if (rst || m_start || (!master && !slave_on)) begin
			shift_reg <= 16'h0000;
		end else if (ev_shift) begin
			shift_reg <= shifted;
		end
	end

	// receive register only changes on the last shift, so reads never see half a word
	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_reg <= 16'h0000;
		end else if (ev_shift && ev_last) begin
			rx_reg <= rx_word;
		end
	end

	// pad enables: a master drives clock and master-out, a selected slave master-in
	always_ff @(posedge mclk) begin
		if (rst) begin
			sck_oe  <= 1'b0;
			mosi_oe <= 1'b0;
			miso_oe <= 1'b0;
			ss_n_oe <= 1'b0;
		end else begin
			sck_oe  <= enable & master;
			mosi_oe <= enable & master;
			miso_oe <= slave_on;
			ss_n_oe <= enable & master & cr1_reg[ssp_pkg::CR1_SEL_OUT];
		end
	end

	// select output low from the start until the tail has run out
	always_ff @(posedge mclk) begin
		if (rst) begin
			ss_n_o <= 1'b1;
		end else begin
			ss_n_o <= (state_reg == SSP_IDLE) & ~m_start;
		end
	end

	// serial clock idles at the polarity level and toggles on each master edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			sck_o <= 1'b0;
		end else if (state_reg == SSP_IDLE) begin
			sck_o <= polarity;
		end else if (m_edge) begin
			sck_o <= ~sck_o;
		end
	end

	// master-out: phase zero sets the first bit before edge one, the next after even edges
	always_ff @(posedge mclk) begin
		if (rst) begin
			mosi_o <= 1'b0;
		end else if (m_start && !phase) begin
			mosi_o <= tx_reg[tx_first];
		end else if (m_edge && !ev_sample && !ev_last) begin
			mosi_o <= tx_reg_bit(1'b1);
		end
	end

	// master-in as slave: the first bit is loaded while deselected, so it stands as select falls
	always_ff @(posedge mclk) begin
		if (rst) begin
			miso_o <= 1'b0;
		end else if (!master && !sel_low) begin
			miso_o <= tx_reg[tx_first];
		end else if (slave_on && ev_shift) begin
			miso_o <= tx_reg_bit(phase);
		end
	end

	// outgoing bit: phase zero with nxt set takes the position after the current one, all other calls the current one
	function automatic logic tx_reg_bit(input logic nxt);
		tx_reg_bit = nxt && !phase ? tx_reg[tx_pos_nx] : tx_reg[tx_pos];
	endfunction : tx_reg_bit

	// status and mask read back with their bits at the same positions
	wire [7:0]   status_rd = {done_reg, 1'b0, empty_reg, 5'h00};
	wire [7:0]   mask_rd   = {mask_reg[1], 1'b0, mask_reg[0], 5'h00};

	// register read mux
	wire [7:0]   rd_data =
		(reg_idx == ssp_pkg::IDX_CTRL_ONE)  ? cr1_reg :
		(reg_idx == ssp_pkg::IDX_CTRL_TWO)  ? cr2_reg :
		(reg_idx == ssp_pkg::IDX_BAUD)      ? baud_reg :
		(reg_idx == ssp_pkg::IDX_STATUS)    ? status_rd :
		(reg_idx == ssp_pkg::IDX_DATA_HIGH) ? rx_reg[15:8] :
		(reg_idx == ssp_pkg::IDX_DATA_LOW)  ? rx_reg[7:0] :
		(reg_idx == ssp_pkg::IDX_IRQ_MASK)  ? mask_rd :
		8'h00;
	wire         irq_next = (done_reg & mask_reg[1] & cr1_reg[ssp_pkg::CR1_IRQ_EN]) |
	                        (txe_ev_reg & mask_reg[0] & cr1_reg[ssp_pkg::CR1_TXE_IRQ]);

	// bus answer one cycle after the request; unmapped addresses get err
	always_ff @(posedge mclk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req & hit;
			wb_err_o <= wb_req & ~hit;
			wb_dat_o <= {24'h000000, rd_data};
		end
	end

	// level interrupt, registered so the pin never glitches while flags settle
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_next;
		end
	end
	wire         unused_rd = rd_low;
endmodule : ssp_serial_port

// ===== ssp_serial_port_chk.sv
// checker for the serial port: bus handshake, pin roles and frame timing
// assumes the bench keeps the baud setting at 0x02, a half period of four clocks
`timescale 1ns/1ns
module ssp_serial_port_chk (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic        irq,
	input wire logic        sck_o,
	input wire logic        sck_oe,
	input wire logic        mosi_o,
	input wire logic        mosi_oe,
	input wire logic        miso_oe,
	input wire logic        ss_n_o
);
	logic       cpol_q, wide_q, en_q, msk_q, sck_q;
	logic [5:0] edges;
	wire        wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
	wire [11:0] idx = wb_adr_i[13:2];
	// shadow of the settings, taken at the ack edge so it never leads the design
	always_ff @(posedge mclk) begin
		if (rst) begin
			{cpol_q, wide_q, en_q, msk_q} <= 4'h0;
		end else if (wr && idx == ssp_pkg::IDX_CTRL_ONE) begin
			{en_q, cpol_q} <= {wb_dat_i[7], wb_dat_i[3]};
		end else if (wr && idx == ssp_pkg::IDX_CTRL_TWO) begin
			wide_q <= wb_dat_i[6];
		end else if (wr && idx == ssp_pkg::IDX_IRQ_MASK) begin
			msk_q <= wb_dat_i[7];
		end
	end
	// serial clock edges seen while the select is low
	always_ff @(posedge mclk) begin
		sck_q <= sck_o;
		edges <= (rst || ss_n_o) ? 6'h00 : edges + {5'h00, sck_o != sck_q};
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_ack_pulse: assert property (
		wb_ack_o |=> !wb_ack_o
	) else $error("ack held longer than one cycle");
	a_bus_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o
	) else $error("bus request left unanswered");
	a_idle_level: assert property (
		sck_oe && ss_n_o && !wb_cyc_i && $past(!wb_cyc_i) |-> sck_o == cpol_q
	) else $error("serial clock not at its idle level");
	a_first_edge: assert property (
		$fell(ss_n_o) && sck_oe |-> $stable(sck_o)[*4] ##1 $changed(sck_o)
	) else $error("first clock edge not half a period after select");
	a_edge_count: assert property (
		$rose(ss_n_o) && sck_oe |-> edges == (wide_q ? ssp_pkg::EDGES_16 : ssp_pkg::EDGES_8)
	) else $error("wrong number of clock edges in a frame");
	a_done_irq: assert property (
		$rose(ss_n_o) && sck_oe && en_q && msk_q |-> ##[0:3] irq
	) else $error("done interrupt missing after the last edge");
	a_master_pins: assert property (
		sck_oe |-> mosi_oe && !miso_oe
	) else $error("master drives the wrong data line");
	a_mosi_shift: assert property (
		$changed(mosi_o) && sck_oe |-> sck_o == cpol_q
	) else $error("master-out changed away from an even edge");
endmodule : ssp_serial_port_chk
bind ssp_serial_port ssp_serial_port_chk chk_u (.mclk(mclk), .rst(rst), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq(irq), .sck_o(sck_o),
	.sck_oe(sck_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n_o(ss_n_o));

// ===== ssp_slave_model.sv
// behavioural far-end device answering the port in the phase-zero format
// assumes polarity, bit order and width are set while it is not selected
`timescale 1ns/1ns
module ssp_slave_model (
	input  wire logic        sck,
	input  wire logic        ss_n,
	input  wire logic        mosi,
	input  wire logic        cpol,
	input  wire logic        lsb,
	input  wire logic [4:0]  nbits,
	input  wire logic [15:0] tx_word,
	output logic             miso,
	output logic [15:0]      rx_word
);
	logic [4:0] k = 5'h00;
	wire        lead = sck ^ cpol;             // leading edge whatever the idle level
	wire  [4:0] pos  = lsb ? k : nbits - 5'h01 - k;
	initial miso = 1'h0;
	// new frame: first bit shows as soon as select falls
	always @(negedge ss_n) begin
		k = 5'h00;
		rx_word = 16'h0000;
	end
	// sample on the leading edges, move to the next bit after the trailing ones
	always @(posedge lead) if (!ss_n) rx_word[pos[3:0]] = mosi;
	always @(negedge lead) if (!ss_n) k = k + 5'h01;
	// released line shows a changed level, never a held copy of the last bit
	always @(ss_n or pos or tx_word) miso = ss_n ? ~miso : tx_word[pos[3:0]];
endmodule : ssp_slave_model

// ===== ssp_serial_port_tb.sv
// bench for the serial port: register access over wishbone and frames
// exchanged with the behavioural far end; the port runs as master throughout
`timescale 1ns/1ns
module ssp_serial_port_tb;
	logic        mclk = 1'h0, rst = 1'h1, we = 1'h0, cyc = 1'h0, stb = 1'h0, berr;
	logic [31:0] adr = 32'h0, dat = 32'h0, dout;
	logic [3:0]  sel = 4'hF;
	logic [7:0]  q;
	logic        ack, err, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic        ss_n_o, ss_n_oe, miso_p, s_cpol = 1'h0, s_lsb = 1'h0;
	logic [4:0]  s_bits = 5'h08;
	logic [15:0] s_tx = 16'h0, s_rx;
	int          fails = 0, samples_checked = 0, cycles = 0;
	localparam logic [7:0]  C1 [3] = '{8'hD2, 8'hDB, 8'hDA};
	localparam logic [7:0]  C2 [3] = '{8'h00, 8'h40, 8'h00};
	localparam logic [7:0]  MK [3] = '{8'h80, 8'h80, 8'h00};
	localparam logic [15:0] MT [3] = '{16'h003C, 16'h1234, 16'h00FF};
	localparam logic [15:0] ST [3] = '{16'h00A5, 16'hC0DE, 16'h0001};
	// pins resolved from the enables; undriven clock rests at the idle level
	wire sck_ln  = sck_oe ? sck_o : s_cpol;
	wire mosi_ln = mosi_oe ? mosi_o : ~mosi_o;
	wire miso_ln = miso_oe ? miso_o : miso_p;
	wire ss_ln   = ss_n_oe ? ss_n_o : 1'h1;
	ssp_serial_port dut_u (.mclk(mclk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_dat_o(dout), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_ack_o(ack), .wb_err_o(err), .irq(irq), .sck_i(sck_ln), .sck_o(sck_o),
		.sck_oe(sck_oe), .mosi_i(mosi_ln), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
		.miso_i(miso_ln), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(1'h1),
		.ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));
	ssp_slave_model far_u (.sck(sck_ln), .ss_n(ss_ln), .mosi(mosi_ln), .cpol(s_cpol),
		.lsb(s_lsb), .nbits(s_bits), .tx_word(s_tx), .miso(miso_p), .rx_word(s_rx));
	initial begin
		forever #25 mclk = ~mclk;
	end
	// cut a hang short
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			results();
		end
	end
	task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d);
		@(posedge mclk);
		{adr, dat, we, cyc, stb} <= {18'h0, i, 2'h0, 24'h0, d, w, 2'h3};
		do @(posedge mclk); while (ack !== 1'h1 && err !== 1'h1);
		q = dout[7:0];
		berr = err;
		{cyc, stb, we} <= 3'h0;
	endtask : bus
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			fails++;
		end
	endtask : chk
	task automatic rdc(input string n, input logic [11:0] i, input logic [7:0] e);
		bus(1'h0, i, 8'h00);
		chk(n, {8'h00, e}, {8'h00, q});
	endtask : rdc
	// one frame with table entry t, then read back and clear the done flag
	task automatic xfer(input int t);
		int w;
		{s_cpol, s_lsb, s_tx} <= {C1[t][3], C1[t][0], ST[t]};
		s_bits <= C2[t][6] ? 5'h10 : 5'h08;
		bus(1'h1, ssp_pkg::IDX_IRQ_MASK, MK[t]);
		bus(1'h1, ssp_pkg::IDX_CTRL_TWO, C2[t]);
		bus(1'h1, ssp_pkg::IDX_CTRL_ONE, C1[t]);
		bus(1'h1, ssp_pkg::IDX_DATA_HIGH, MT[t][15:8]);
		bus(1'h1, ssp_pkg::IDX_DATA_LOW, MT[t][7:0]);
		w = 0;
		do begin
			bus(1'h0, ssp_pkg::IDX_STATUS, 8'h00);
			w++;
		end while (q[7] !== 1'h1 && w < 200);
		chk("done", 16'h1, {15'h0, q[7]});
		chk("empty", 16'h1, {15'h0, q[5]});
		chk("select_oe", 16'h1, {15'h0, ss_n_oe});
		chk("irq", {15'h0, MK[t][7]}, {15'h0, irq});
		chk("slave_rx", MT[t] & (C2[t][6] ? 16'hFFFF : 16'h00FF), s_rx);
		rdc("data_low", ssp_pkg::IDX_DATA_LOW, ST[t][7:0]);
		if (C2[t][6]) rdc("data_high", ssp_pkg::IDX_DATA_HIGH, ST[t][15:8]);
		chk("sck_idle", {15'h0, C1[t][3]}, {15'h0, sck_o});
		bus(1'h1, ssp_pkg::IDX_STATUS, 8'h80);
		bus(1'h0, ssp_pkg::IDX_STATUS, 8'h00);
		chk("done_clear", 16'h0, {15'h0, q[7]});
		chk("irq_clear", 16'h0, {15'h0, irq});
	endtask : xfer
	task automatic results;
		if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'h0;
		rdc("ctrl_one", ssp_pkg::IDX_CTRL_ONE, ssp_pkg::CR1_RESET);
		rdc("ctrl_two", ssp_pkg::IDX_CTRL_TWO, ssp_pkg::CR2_RESET);
		rdc("baud", ssp_pkg::IDX_BAUD, ssp_pkg::BAUD_RESET);
		rdc("reserved", ssp_pkg::IDX_RSVD_B, 8'h00);
		bus(1'h0, 12'h7F0, 8'h00);
		chk("unmapped_err", 16'h1, {15'h0, berr});
		bus(1'h1, ssp_pkg::IDX_BAUD, 8'h02);
		for (int t = 0; t < 3; t++) xfer(t);
		results();
	end
endmodule : ssp_serial_port_tb
